// *** hdl/pcu_capture_two.sv ***
// Second position capture channel and shared capture status word
// Notes on behaviour
// - Stop code cancels capture in progress; no further positions latched.
// - Single-shot code arms the channel to latch exactly one position.
// - Continuous code arms the channel to latch on every qualifying edge.
// - Single-shot disarms itself once the first position is latched.
// - Continuous stays armed after each capture until stopped.
// - Edge select 0 captures falling, 1 captures rising; default 0.
// - Qualifying edge latches signed 32-bit position into read-only register.
// - Stored captured position is recomputed when position reference changes.
// - Read-only 16-bit counter increments once per capture event.
// - Event counter clears to zero on a start command.
// - Status bit 0 sets when first input completes a capture.
// - Status bit 1 sets when second input completes a capture.
`timescale 1ns/100ps
module pcu_capture_two #(
   parameter int POS_W = pcu_pkg::POS_WIDTH,
   parameter int CNT_W = pcu_pkg::DATA_WIDTH
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Parameter access
   input  wire logic [15:0]              regAddr,
   input  wire logic                     regWrEn,
   input  wire logic [15:0]              regWrData,
   input  wire logic                     regRdEn,
   output logic      [31:0]              regRdData,
   output logic                          regRdValid,
   // Capture pin
   input  wire logic                     secondCaptureInput,
   // Drive position and reference changes
   input  wire logic signed [POS_W-1:0]  positionNow,
   input  wire logic                     refShiftValid,
   input  wire logic signed [POS_W-1:0]  refShiftDelta,
   // First channel events
   input  wire logic                     firstCaptureDone,
   input  wire logic                     firstCaptureStart
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pcu_pkg::pcu_mode_type      mode_ff;
   pcu_pkg::pcu_mode_type      nxt_mode;
   logic                       edgeSel_ff;
   logic signed [POS_W-1:0]    latchedPos_ff;
   logic signed [POS_W-1:0]    nxt_latchedPos;
   logic [CNT_W-1:0]           eventCount_ff;
   logic [CNT_W-1:0]           nxt_eventCount;
   logic                       statFirst_ff;
   logic                       statSecond_ff;
   logic [31:0]                regRdData_ff;
   logic                       regRdValid_ff;
   logic                       edgeHit;

   function automatic logic addrIs(input logic [15:0] a,
                                   input logic [15:0] off);
      addrIs = (a == off);
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire wrEdge  = regWrEn && addrIs(regAddr, pcu_pkg::ADDR_EDGE_SELECT);
   wire wrRun   = regWrEn && addrIs(regAddr, pcu_pkg::ADDR_RUN_CONTROL);
   wire cmdStop = wrRun && (regWrData == pcu_pkg::RUN_STOP);
   wire cmdOnce = wrRun && (regWrData == pcu_pkg::RUN_ONCE);
   wire cmdCont = wrRun && (regWrData == pcu_pkg::RUN_CONTINUOUS);
   wire cmdStart = cmdOnce || cmdCont;
   // A run-control write in the same cycle as an edge takes priority
   wire takeCapture = edgeHit && (mode_ff != pcu_pkg::PCU_IDLE) && !wrRun;

   pcu_edge_sync u_edge (
      .clk       (clk),
      .rst_b     (rst_b),
      .pinIn     (secondCaptureInput),
      .risingSel (edgeSel_ff),
      .edgeHit   (edgeHit)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      if (cmdStop) begin
         nxt_mode = pcu_pkg::PCU_IDLE;
      end else if (cmdOnce) begin
         nxt_mode = pcu_pkg::PCU_ONCE;
      end else if (cmdCont) begin
         nxt_mode = pcu_pkg::PCU_CONT;
      end else if (takeCapture) begin
         case (mode_ff)
            pcu_pkg::PCU_ONCE: nxt_mode = pcu_pkg::PCU_IDLE;
            pcu_pkg::PCU_CONT: nxt_mode = pcu_pkg::PCU_CONT;
            default:           nxt_mode = pcu_pkg::PCU_IDLE;
         endcase
      end
   end

   // A capture in the new reference wins over a reference shift
   assign nxt_latchedPos = takeCapture ? positionNow :
                           refShiftValid ?
                           POS_W'(latchedPos_ff + refShiftDelta) :
                           latchedPos_ff;
   assign nxt_eventCount = cmdStart ? CNT_W'(pcu_pkg::RST_COUNT) :
                           takeCapture ?
                           CNT_W'(eventCount_ff + pcu_pkg::COUNT_STEP) :
                           eventCount_ff;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire [15:0] statusWord = {14'h0000, statSecond_ff, statFirst_ff};
   wire [15:0] runWord    = {14'h0000, mode_ff};
   wire [31:0] rdMux =
      addrIs(regAddr, pcu_pkg::ADDR_STATUS_FLAGS) ? {16'h0000, statusWord} :
      addrIs(regAddr, pcu_pkg::ADDR_EDGE_SELECT)  ?
         {31'h0000_0000, edgeSel_ff} :
      addrIs(regAddr, pcu_pkg::ADDR_RUN_CONTROL)  ? {16'h0000, runWord} :
      addrIs(regAddr, pcu_pkg::ADDR_LATCHED_POS)  ? 32'(latchedPos_ff) :
      addrIs(regAddr, pcu_pkg::ADDR_EVENT_COUNT)  ?
         {16'h0000, 16'(eventCount_ff)} : 32'h0000_0000;

   assign regRdData  = regRdData_ff;
   assign regRdValid = regRdValid_ff;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff       <= pcu_pkg::PCU_IDLE;
         edgeSel_ff    <= pcu_pkg::RST_EDGE_SELECT;
         latchedPos_ff <= POS_W'(pcu_pkg::RST_POSITION);
         eventCount_ff <= CNT_W'(pcu_pkg::RST_COUNT);
      end else begin
         mode_ff       <= nxt_mode;
         latchedPos_ff <= nxt_latchedPos;
         eventCount_ff <= nxt_eventCount;
         if (wrEdge) begin
            edgeSel_ff <= regWrData[0];
         end
      end
   end

   // Set wins over clear on the first flag; a start blocks a same-cycle capture, so the second flag clears
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         statFirst_ff  <= 1'h0;
         statSecond_ff <= 1'h0;
      end else begin
         if (firstCaptureDone) begin
            statFirst_ff <= 1'h1;
         end else if (firstCaptureStart) begin
            statFirst_ff <= 1'h0;
         end
         if (takeCapture) begin
            statSecond_ff <= 1'h1;
         end else if (cmdStart) begin
            statSecond_ff <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData_ff  <= 32'h0000_0000;
         regRdValid_ff <= 1'h0;
      end else begin
         regRdValid_ff <= regRdEn;
         regRdData_ff  <= regRdEn ? rdMux : regRdData_ff;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence armOnce;
      cmdOnce ##1 (mode_ff == pcu_pkg::PCU_ONCE);
   endsequence
   sequence hitWhileOnce;
      (mode_ff == pcu_pkg::PCU_ONCE) && edgeHit && !wrRun;
   endsequence

   chk_stop_cancels: assert property (cmdStop |=>
      (mode_ff == pcu_pkg::PCU_IDLE) && !takeCapture)
      else $error("stop did not cancel capture");
   chk_once_arms: assert property (cmdOnce |-> armOnce)
      else $error("single-shot code did not arm");
   chk_cont_arms: assert property (cmdCont |=>
      mode_ff == pcu_pkg::PCU_CONT)
      else $error("continuous code did not arm");
   chk_once_disarm: assert property (hitWhileOnce |=>
      (mode_ff == pcu_pkg::PCU_IDLE) && (statSecond_ff == 1'h1))
      else $error("single-shot did not disarm after capture");
   chk_cont_stays: assert property (
      (mode_ff == pcu_pkg::PCU_CONT) && takeCapture |=>
      mode_ff == pcu_pkg::PCU_CONT)
      else $error("continuous mode left after capture");
   chk_pos_latch: assert property (takeCapture |=>
      latchedPos_ff == $past(positionNow))
      else $error("captured position mismatch");
   chk_pos_shift: assert property (
      refShiftValid && !takeCapture |=>
      latchedPos_ff == POS_W'($past(latchedPos_ff) + $past(refShiftDelta)))
      else $error("position not recomputed on reference change");
   chk_count_step: assert property (
      takeCapture |=>
      eventCount_ff == CNT_W'($past(eventCount_ff) + pcu_pkg::COUNT_STEP))
      else $error("event counter did not step");
   chk_count_clear: assert property (cmdStart |=>
      eventCount_ff == pcu_pkg::RST_COUNT)
      else $error("event counter not cleared on start");
   chk_first_flag: assert property (firstCaptureDone |=>
      statFirst_ff)
      else $error("first completion flag not set");
   chk_second_flag: assert property (cmdStart ##1 !takeCapture |->
      !statSecond_ff)
      else $error("second completion flag not cleared on start");
   chk_flag_read: assert property (
      regRdEn && addrIs(regAddr, pcu_pkg::ADDR_STATUS_FLAGS) |=>
      regRdValid_ff && regRdData_ff[pcu_pkg::STAT_SECOND_BIT] ==
      $past(statSecond_ff))
      else $error("status word does not show second flag");
endmodule

// *** hdl/pcu_pkg.sv ***
// Shared constants for the position capture unit, second channel
package pcu_pkg;
   // ------------------------------------------------------------
   // Parameter addresses
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_STATUS_FLAGS = 16'h0A02;
   localparam logic [15:0] ADDR_EDGE_SELECT  = 16'h0A06;
   localparam logic [15:0] ADDR_RUN_CONTROL  = 16'h0A0A;
   localparam logic [15:0] ADDR_LATCHED_POS  = 16'h0A0E;
   localparam logic [15:0] ADDR_EVENT_COUNT  = 16'h0A12;

   // ------------------------------------------------------------
   // Run-control codes and edge selection
   // ------------------------------------------------------------
   localparam logic [15:0] RUN_STOP       = 16'h0000;
   localparam logic [15:0] RUN_ONCE       = 16'h0001;
   localparam logic [15:0] RUN_CONTINUOUS = 16'h0002;
   localparam logic        EDGE_FALLING   = 1'h0;
   localparam logic        EDGE_RISING    = 1'h1;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          STAT_FIRST_BIT  = 0;
   localparam int          STAT_SECOND_BIT = 1;
   localparam int          DATA_WIDTH      = 16;
   localparam int          POS_WIDTH       = 32;
   localparam logic        RST_EDGE_SELECT = EDGE_FALLING;
   localparam logic [31:0] RST_POSITION    = 32'h0000_0000;
   localparam logic [15:0] RST_COUNT       = 16'h0000;
   localparam logic [15:0] COUNT_STEP      = 16'h0001;

   typedef enum logic [1:0] {
      PCU_IDLE = 2'b00,
      PCU_ONCE = 2'b01,
      PCU_CONT = 2'b10
   } pcu_mode_type;
endpackage

// *** hdl/pcu_edge_sync.sv ***
// Capture pin synchroniser with selectable edge detection
`timescale 1ns/100ps
module pcu_edge_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Pin and selection
   input  wire logic pinIn,
   input  wire logic risingSel,
   // Detected edge, one-cycle pulse
   output logic      edgeHit
);
   logic syncA_ff;
   logic syncB_ff;
   logic prev_ff;
   logic edgeHit_ff;
   wire  riseSeen;
   wire  fallSeen;
   wire  nxt_edgeHit;

   // Only syncB_ff and prev_ff feed the detector, never syncA_ff
   assign riseSeen    = syncB_ff & ~prev_ff;
   assign fallSeen    = ~syncB_ff & prev_ff;
   assign nxt_edgeHit = risingSel ? riseSeen : fallSeen;
   assign edgeHit     = edgeHit_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA_ff   <= 1'h0;
         syncB_ff   <= 1'h0;
         prev_ff    <= 1'h0;
         edgeHit_ff <= 1'h0;
      end else begin
         syncA_ff   <= pinIn;
         syncB_ff   <= syncA_ff;
         prev_ff    <= syncB_ff;
         edgeHit_ff <= nxt_edgeHit;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_edge_polarity: assert property (
      edgeHit_ff |-> ($past(risingSel) ? ($past(syncB_ff) && !$past(prev_ff))
                                      : (!$past(syncB_ff) && $past(prev_ff))))
      else $error("edge pulse does not match selected polarity");
endmodule

// *** tb/pcu_pin_model.sv ***
// Behavioural model of the external capture signal line
`timescale 1ns/100ps
module pcu_pin_model (
   // Pacing clock
   input  wire logic clk,
   // Capture line
   output logic      pinLevel
);
   initial pinLevel = 1'h0;

   // Each level is held five cycles: pulses shorter than one cycle may be
   // lost by the synchroniser, so the model never makes them
   task automatic setLevel(input logic v);
      @(negedge clk);
      pinLevel = v;
      repeat (5) @(negedge clk);
   endtask
endmodule

// *** tb/tb_position_capture_unit.sv ***
// Self-checking testbench for the second position capture channel
`timescale 1ns/100ps
module tb_position_capture_unit;
   typedef struct {
      logic [15:0] addr;
      logic        wr;
      logic [15:0] wd;
      logic [31:0] exp;
   } pcu_row_type;

   logic               clk;
   logic               rst_b;
   logic [15:0]        regAddr;
   logic               regWrEn;
   logic [15:0]        regWrData;
   logic               regRdEn;
   logic [31:0]        regRdData;
   logic               regRdValid;
   logic               pinLevel;
   logic signed [31:0] posNow;
   logic               refShiftValid;
   logic signed [31:0] refShiftDelta;
   logic               firstDone;
   logic               firstStart;
   int                 fails;
   int                 comparisons;
   // Channel-one pulses: done alone, start alone, both at once (done wins)
   logic [1:0]         flagPat [3] = '{2'h2, 2'h1, 2'h3};
   logic [31:0]        flagExp [3] = '{32'h0000_0003, 32'h0000_0002,
                                       32'h0000_0003};

   // ------------------------------------------------------------
   // Reset view and access kinds, unmapped address included
   // ------------------------------------------------------------
   pcu_row_type rows [8] = '{
      '{16'h0A02, 1'h0, 16'h0000, 32'h0000_0000},
      '{16'h0A06, 1'h0, 16'h0000, 32'h0000_0000},
      '{16'h0A0A, 1'h0, 16'h0000, 32'h0000_0000},
      '{16'h0A0E, 1'h0, 16'h0000, 32'h0000_0000},
      '{16'h0A12, 1'h0, 16'h0000, 32'h0000_0000},
      '{16'h0A04, 1'h1, 16'h5A5A, 32'h0000_0000},
      '{16'h0A0E, 1'h1, 16'h1234, 32'h0000_0000},
      '{16'h0A0A, 1'h1, 16'h0005, 32'h0000_0000}};

   pcu_capture_two u_dut (
      .clk               (clk),
      .rst_b             (rst_b),
      .regAddr           (regAddr),
      .regWrEn           (regWrEn),
      .regWrData         (regWrData),
      .regRdEn           (regRdEn),
      .regRdData         (regRdData),
      .regRdValid        (regRdValid),
      .secondCaptureInput(pinLevel),
      .positionNow       (posNow),
      .refShiftValid     (refShiftValid),
      .refShiftDelta     (refShiftDelta),
      .firstCaptureDone  (firstDone),
      .firstCaptureStart (firstStart)
   );

   pcu_pin_model u_pin (
      .clk     (clk),
      .pinLevel(pinLevel)
   );

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'h1) begin
         fails++;
         $display("BAD t=%0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      regAddr   = a;
      regWrData = d;
      regWrEn   = 1'h1;
      @(negedge clk);
      regWrEn   = 1'h0;
   endtask

   task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'h1;
      @(negedge clk);
      regRdEn = 1'h0;
      check(regRdValid === 1'h1 && regRdData === e, $sformatf(
            "read %h gave %h want %h", a, regRdData, e));
   endtask

   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run is about 150 cycles; this is a generous ceiling
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      final_report;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {regAddr, regWrEn, regWrData, regRdEn} = '0;
      {refShiftValid, refShiftDelta, firstDone, firstStart} = '0;
      fails = 0;
      comparisons = 0;
      posNow = 32'sh0000_0000;
      rst_b = 1'h0;
      repeat (8) @(posedge clk);
      @(negedge clk) rst_b = 1'h1;
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr(rows[i].addr, rows[i].wd);
         rdChk(rows[i].addr, rows[i].exp);
      end
      wr(16'h0A06, 16'hFFFF);
      rdChk(16'h0A06, 32'h0000_0001);
      $display("test registers done");
      // Single shot on rising edge, then a second edge must be ignored
      wr(pcu_pkg::ADDR_RUN_CONTROL, pcu_pkg::RUN_ONCE);
      posNow = 32'sh8000_0005;
      u_pin.setLevel(1'h1);
      rdChk(pcu_pkg::ADDR_LATCHED_POS, 32'h8000_0005);
      rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'h0000_0001);
      rdChk(pcu_pkg::ADDR_STATUS_FLAGS, 32'h0000_0002);
      rdChk(pcu_pkg::ADDR_RUN_CONTROL, 32'h0000_0000);
      u_pin.setLevel(1'h0);
      posNow = 32'sh0000_0777;
      u_pin.setLevel(1'h1);
      rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'h0000_0001);
      $display("test single shot done");
      // Continuous on falling edges; rising edges carry a decoy position
      wr(pcu_pkg::ADDR_EDGE_SELECT, 16'h0000);
      wr(pcu_pkg::ADDR_RUN_CONTROL, pcu_pkg::RUN_CONTINUOUS);
      rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'h0000_0000);
      rdChk(pcu_pkg::ADDR_STATUS_FLAGS, 32'h0000_0000);
      for (int i = 1; i <= 3; i++) begin
         posNow = 32'sh0000_0100 + i;
         u_pin.setLevel(1'h0);
         posNow = 32'shDEAD_0000;
         u_pin.setLevel(1'h1);
         rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'(i));
      end
      rdChk(pcu_pkg::ADDR_LATCHED_POS, 32'h0000_0103);
      rdChk(pcu_pkg::ADDR_RUN_CONTROL, 32'h0000_0002);
      // A reference shift moves the stored position by its delta
      @(negedge clk);
      refShiftDelta = -32'sd4;
      refShiftValid = 1'h1;
      @(negedge clk) refShiftValid = 1'h0;
      rdChk(pcu_pkg::ADDR_LATCHED_POS, 32'h0000_00FF);
      $display("test continuous done");
      // Stop cancels, later falling edge is not counted
      wr(pcu_pkg::ADDR_RUN_CONTROL, pcu_pkg::RUN_STOP);
      u_pin.setLevel(1'h0);
      rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'h0000_0003);
      // First channel flag sets bit 0 and its re-arm clears it
      for (int k = 0; k < 3; k++) begin
         @(negedge clk) {firstDone, firstStart} = flagPat[k];
         @(negedge clk) {firstDone, firstStart} = 2'h0;
         rdChk(pcu_pkg::ADDR_STATUS_FLAGS, flagExp[k]);
      end
      $display("test stop and flags done");
      // Reset in mid-run clears the read port and the counter
      @(negedge clk) rst_b = 1'h0;
      @(negedge clk);
      check(regRdValid === 1'h0 && regRdData === 32'h0, "reset read");
      rst_b = 1'h1;
      rdChk(pcu_pkg::ADDR_EVENT_COUNT, 32'h0000_0000);
      $display("test second reset done");
      final_report;
   end
endmodule
